/* core/gtc_core.sv */
// general timer control core: counter, update logic, register bank
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module gtc_core
  import gtc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic triggerIn,
  input wire logic followerUpdate,
  output logic [15:0] rdata,
  output logic irq,
  output logic sampleTick,
  output logic [3:0] cmpOut
);

  gtc_bus_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wrStb, rd: rdStb};

  logic [15:0] ctrlOne_q, ctrlTwo_q, follower_q, irqEn_q, flags_q;
  logic [15:0] chMode1_q, chMode2_q, chOutEn_q, burstCtrl_q, burstWin_q;
  logic [15:0] count_q, pscBuf_q, pscAct_q, pscCnt_q, reloadBuf_q, reloadAct_q;
  logic [15:0] cmpBuf_q [4];
  logic [15:0] cmpAct_q [4];
  logic trigSeen_q, centreDown_q;
  logic [1:0] divCnt_q;
  logic [15:0] rdata_d;

  wire runEn = ctrlOne_q[RUN_BIT];
  wire gtc_align_t alignMode = gtc_align_t'(ctrlOne_q[ALIGN_LO +: 2]);
  wire centred = (alignMode != ALIGN_EDGE);
  wire countDown = ctrlOne_q[DIR_BIT];

  // ==========================================================
  // write decode
  wire wrCtrl = req.wr && (req.addr == OFF_CTRL_ONE);
  wire wrSwEv = req.wr && (req.addr == OFF_SW_EVENT);
  wire wrCount = req.wr && (req.addr == OFF_COUNT);
  wire swUpdate = wrSwEv && req.wdata[FLG_UPDATE];
  wire swTrigger = wrSwEv && req.wdata[FLG_TRIGGER];

  // ==========================================================
  // count tick and wrap detection
  wire pscDone = (pscCnt_q >= pscAct_q);
  wire tick = runEn && pscDone;
  wire upEnd = (count_q >= reloadAct_q);
  wire downEnd = (count_q == ZERO16);
  logic wrapEv;
  always_comb begin
    if (centred) begin
      wrapEv = tick && (centreDown_q ? (count_q == ONE16) : (count_q == reloadAct_q - ONE16)
        || (reloadAct_q == ZERO16));
    end else begin
      wrapEv = tick && (countDown ? downEnd : upEnd);
    end
  end

  wire trigRise = triggerIn && !trigSeen_q;
  wire trigStart = (follower_q[2:0] == FOLLOW_TRIGGER) && trigRise;
  wire updateEv = !ctrlOne_q[INHIBIT_BIT] && (wrapEv || swUpdate || followerUpdate);
  wire updateFlagEv = updateEv && (wrapEv || !ctrlOne_q[URS_BIT]);

  // ==========================================================
  // control_one with hardware-driven bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrlOne_q <= CTRL_ONE_RESET;
    end else begin
      if (wrCtrl) begin
        ctrlOne_q <= req.wdata & CTRL_ONE_MASK;
        if (centred) begin
          ctrlOne_q[DIR_BIT] <= ctrlOne_q[DIR_BIT];
        end else if (req.wdata[ALIGN_LO +: 2] != 2'b00) begin
          ctrlOne_q[DIR_BIT] <= 1'b0;
        end
      end else begin
        if (centred) begin
          ctrlOne_q[DIR_BIT] <= centreDown_q;
        end
        if (trigStart) begin
          ctrlOne_q[RUN_BIT] <= 1'b1;
        end
        if (updateEv && ctrlOne_q[ONESHOT_BIT]) begin
          ctrlOne_q[RUN_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trigSeen_q <= 1'b0;
    end else begin
      trigSeen_q <= triggerIn;
    end
  end

  // ==========================================================
  // prescaler and counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pscCnt_q <= ZERO16;
    end else if (updateEv || !runEn || pscDone) begin
      pscCnt_q <= ZERO16;
    end else begin
      pscCnt_q <= pscCnt_q + ONE16;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= ZERO16;
      centreDown_q <= 1'b0;
    end else if (wrCount) begin
      count_q <= req.wdata;
    end else if (!runEn && wrCtrl) begin
      centreDown_q <= 1'b0;
    end else if (centred) begin
      if (tick) begin
        if (centreDown_q) begin
          count_q <= count_q - ONE16;
          if (count_q == ONE16) begin
            centreDown_q <= 1'b0;
          end
        end else begin
          count_q <= count_q + ONE16;
          if (count_q + ONE16 >= reloadAct_q) begin
            centreDown_q <= 1'b1;
          end
        end
      end
    end else if (swUpdate && updateEv) begin
      count_q <= countDown ? reloadAct_q : ZERO16;
    end else if (tick) begin
      if (countDown) begin
        count_q <= downEnd ? reloadAct_q : count_q - ONE16;
      end else begin
        count_q <= upEnd ? ZERO16 : count_q + ONE16;
      end
    end
  end

  // ==========================================================
  // buffered and active copies
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reloadBuf_q <= ZERO16;
      reloadAct_q <= ZERO16;
      pscBuf_q <= ZERO16;
      pscAct_q <= ZERO16;
    end else begin
      if (req.wr && req.addr == OFF_RELOAD) begin
        reloadBuf_q <= req.wdata;
        if (!ctrlOne_q[PRELOAD_BIT]) begin
          reloadAct_q <= req.wdata;
        end
      end else if (updateEv) begin
        reloadAct_q <= reloadBuf_q;
      end
      if (req.wr && req.addr == OFF_PRESCALE) begin
        pscBuf_q <= req.wdata;
      end else if (updateEv) begin
        pscAct_q <= pscBuf_q;
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : gCmp
    wire [7:0] cmpOff = OFF_CMP1 + 8'(4 * i);
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cmpBuf_q[i] <= ZERO16;
        cmpAct_q[i] <= ZERO16;
      end else begin
        if (req.wr && req.addr == cmpOff) begin
          cmpBuf_q[i] <= req.wdata;
        end else if (updateEv) begin
          cmpAct_q[i] <= cmpBuf_q[i];
        end
      end
    end
  end

  // ==========================================================
  // compare flags gated by alignment mode
  logic [3:0] cmpHit;
  logic flagDirOk;
  always_comb begin
    case (alignMode)
      ALIGN_EDGE: flagDirOk = 1'b1;
      ALIGN_DOWN_FLAGS: flagDirOk = centreDown_q;
      ALIGN_UP_FLAGS: flagDirOk = !centreDown_q;
      ALIGN_BOTH_FLAGS: flagDirOk = 1'b1;
      default: flagDirOk = 1'b0;
    endcase
    for (int k = 0; k < 4; k++) begin
      cmpHit[k] = tick && flagDirOk && (count_q == cmpAct_q[k]);
    end
  end

  // ==========================================================
  // status flags: set wins over write-one-to-clear
  logic [15:0] flagSet;
  always_comb begin
    flagSet = ZERO16;
    flagSet[FLG_UPDATE] = updateFlagEv;
    flagSet[FLG_CMP_LO +: 4] = cmpHit | (wrSwEv ? req.wdata[FLG_CMP_LO +: 4] : 4'h0);
    flagSet[FLG_TRIGGER] = trigStart || swTrigger;
  end

  wire [15:0] flagClr = (req.wr && req.addr == OFF_FLAGS) ? req.wdata : ZERO16;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= ZERO16;
    end else begin
      flags_q <= ((flags_q & ~flagClr) | flagSet) & FLAG_MASK;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_q & irqEn_q);
    end
  end

  // ==========================================================
  // plain storage registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrlTwo_q <= ZERO16;
      follower_q <= ZERO16;
      irqEn_q <= ZERO16;
      chMode1_q <= ZERO16;
      chMode2_q <= ZERO16;
      chOutEn_q <= ZERO16;
      burstCtrl_q <= ZERO16;
      burstWin_q <= ZERO16;
    end else if (req.wr) begin
      case (req.addr)
        OFF_CTRL_TWO: ctrlTwo_q <= req.wdata;
        OFF_FOLLOWER: follower_q <= req.wdata;
        OFF_IRQ_EN: irqEn_q <= req.wdata & FLAG_MASK;
        OFF_CH_MODE_ONE: chMode1_q <= req.wdata;
        OFF_CH_MODE_TWO: chMode2_q <= req.wdata;
        OFF_CH_OUT_EN: chOutEn_q <= req.wdata;
        OFF_BURST_CTRL: burstCtrl_q <= req.wdata;
        OFF_BURST_WIN: burstWin_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sampling clock divider
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= 2'h0;
      sampleTick <= 1'b0;
    end else begin
      case (ctrlOne_q[DIV_LO +: 2])
        2'h1: sampleTick <= (divCnt_q[0] == 1'b1);
        2'h2: sampleTick <= (divCnt_q == 2'h3);
        default: sampleTick <= 1'b1;
      endcase
      divCnt_q <= divCnt_q + 2'h1;
    end
  end

  // ==========================================================
  // channel outputs frozen whenever the run bit is clear, as after the one-shot stop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmpOut <= 4'h0;
    end else if (runEn) begin
      for (int k = 0; k < 4; k++) begin
        cmpOut[k] <= chOutEn_q[4 * k] && (count_q < cmpAct_q[k]);
      end
    end
  end

  // ==========================================================
  // read bank
  always_comb begin
    case (req.addr)
      OFF_CTRL_ONE: rdata_d = ctrlOne_q & CTRL_ONE_MASK;
      OFF_CTRL_TWO: rdata_d = ctrlTwo_q;
      OFF_FOLLOWER: rdata_d = follower_q;
      OFF_IRQ_EN: rdata_d = irqEn_q;
      OFF_FLAGS: rdata_d = flags_q;
      OFF_SW_EVENT: rdata_d = ZERO16;
      OFF_CH_MODE_ONE: rdata_d = chMode1_q;
      OFF_CH_MODE_TWO: rdata_d = chMode2_q;
      OFF_CH_OUT_EN: rdata_d = chOutEn_q;
      OFF_COUNT: rdata_d = count_q;
      OFF_PRESCALE: rdata_d = pscBuf_q;
      OFF_RELOAD: rdata_d = reloadBuf_q;
      OFF_CMP1: rdata_d = cmpBuf_q[0];
      OFF_CMP2: rdata_d = cmpBuf_q[1];
      OFF_CMP3: rdata_d = cmpBuf_q[2];
      OFF_CMP4: rdata_d = cmpBuf_q[3];
      OFF_BURST_CTRL: rdata_d = burstCtrl_q;
      OFF_BURST_WIN: rdata_d = burstWin_q;
      default: rdata_d = ZERO16;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= ZERO16;
    end else begin
      rdata <= req.rd ? rdata_d : ZERO16;
    end
  end

endmodule : gtc_core

/* core/gtc_pkg.sv */
// package: register map, control fields and constants of the timer control core
package gtc_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_FOLLOWER = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_SW_EVENT = 8'h14;
  localparam logic [7:0] OFF_CH_MODE_ONE = 8'h18;
  localparam logic [7:0] OFF_CH_MODE_TWO = 8'h1C;
  localparam logic [7:0] OFF_CH_OUT_EN = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_PRESCALE = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2C;
  localparam logic [7:0] OFF_CMP1 = 8'h34;
  localparam logic [7:0] OFF_CMP2 = 8'h38;
  localparam logic [7:0] OFF_CMP3 = 8'h3C;
  localparam logic [7:0] OFF_CMP4 = 8'h40;
  localparam logic [7:0] OFF_BURST_CTRL = 8'h48;
  localparam logic [7:0] OFF_BURST_WIN = 8'h4C;

  // ==========================================================
  // control_one fields
  localparam int RUN_BIT = 0;
  localparam int INHIBIT_BIT = 1;
  localparam int URS_BIT = 2;
  localparam int ONESHOT_BIT = 3;
  localparam int DIR_BIT = 4;
  localparam int ALIGN_LO = 5;
  localparam int PRELOAD_BIT = 7;
  localparam int DIV_LO = 8;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h03FF;

  // ==========================================================
  // flag bits (status, mask and software event share this layout)
  localparam int FLG_UPDATE = 0;
  localparam int FLG_CMP_LO = 1;
  localparam int FLG_TRIGGER = 6;
  localparam logic [15:0] FLAG_MASK = 16'h005F;

  // follower mode code for trigger start, in bits 2:0
  localparam logic [2:0] FOLLOW_TRIGGER = 3'h6;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;

  typedef enum logic [1:0] {
    ALIGN_EDGE,
    ALIGN_DOWN_FLAGS,
    ALIGN_UP_FLAGS,
    ALIGN_BOTH_FLAGS
  } gtc_align_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gtc_bus_req_t;

endpackage : gtc_pkg

/* verif/gtc_core_chk.sv */
// checker: port-level assertions for the timer control core
`timescale 1ns/1ps
module gtc_core_chk
  import gtc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic triggerIn,
  input wire logic followerUpdate,
  input wire logic [15:0] rdata,
  input wire logic irq,
  input wire logic sampleTick,
  input wire logic [3:0] cmpOut
);
  // ==========================================================
  // shadows of written control and mask, settle counter
  logic [15:0] ctrlSh_q;
  logic [15:0] maskSh_q;
  logic [3:0] since_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrlSh_q <= ZERO16;
      maskSh_q <= ZERO16;
      since_q <= 4'h0;
    end else begin
      if (wrStb && addr == OFF_CTRL_ONE) ctrlSh_q <= wdata;
      if (wrStb && addr == OFF_IRQ_EN) maskSh_q <= wdata;
      if (wrStb && addr == OFF_CTRL_ONE) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_read_idle_zero: assert property (!rdStb |=> rdata == ZERO16)
    else $error("read data not zero outside a read");
  a_ctrl_reserved_zero: assert property (rdStb && addr == OFF_CTRL_ONE |=> rdata[15:10] == 6'h00)
    else $error("reserved control bits not zero");
  a_unmapped_reads_zero: assert property (rdStb && addr == 8'h30 |=> rdata == ZERO16)
    else $error("unmapped address read not zero");
  a_event_reads_zero: assert property (rdStb && addr == OFF_SW_EVENT |=> rdata == ZERO16)
    else $error("event register read not zero");
  a_reload_readback: assert property (wrStb && addr == OFF_RELOAD ##1 rdStb && addr == OFF_RELOAD
    |=> rdata == $past(wdata, 2)) else $error("reload readback wrong");
  a_ctrl_readback: assert property ($past(wrStb) && $past(addr) == OFF_CTRL_ONE && rdStb &&
    addr == OFF_CTRL_ONE |=> rdata[9:5] == ctrlSh_q[9:5] && rdata[3:1] == ctrlSh_q[3:1])
    else $error("control readback wrong");
  a_tick_every_cycle: assert property (since_q == 4'hF && ctrlSh_q[9:8] != 2'b01 &&
    ctrlSh_q[9:8] != 2'b10 |-> sampleTick) else $error("sample tick missing");
  a_tick_half_rate: assert property (since_q == 4'hF && ctrlSh_q[9:8] == 2'b01 && sampleTick
    |=> !sampleTick ##1 sampleTick) else $error("sample tick not every 2");
  a_tick_quarter_rate: assert property (since_q == 4'hF && ctrlSh_q[9:8] == 2'b10 && sampleTick
    |=> !sampleTick [*3] ##1 sampleTick) else $error("sample tick not every 4");
  a_irq_masked_low: assert property (maskSh_q == ZERO16 && $past(maskSh_q) == ZERO16 &&
    $past(maskSh_q, 2) == ZERO16 |-> !irq) else $error("irq high while masked");
  c_reload_rb: cover property (wrStb && addr == OFF_RELOAD ##1 rdStb && addr == OFF_RELOAD);
  c_tick_four: cover property (since_q == 4'hF && ctrlSh_q[9:8] == 2'b10 && sampleTick);
  c_irq_rise: cover property ($rose(irq));
endmodule : gtc_core_chk

bind gtc_core gtc_core_chk u_chk (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
  .wrStb(wrStb), .rdStb(rdStb), .triggerIn(triggerIn), .followerUpdate(followerUpdate),
  .rdata(rdata), .irq(irq), .sampleTick(sampleTick), .cmpOut(cmpOut));

/* verif/gtc_core_tb.sv */
// testbench: self-checking bench for the timer control core
`timescale 1ns/1ps
module gtc_core_tb
  import gtc_pkg::*;
();
  typedef struct {string what; logic [15:0] exp; logic [15:0] msk;} gtc_note_t;
  logic clock;
  logic arst_n;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wrStb;
  logic rdStb;
  logic triggerIn;
  logic followerUpdate;
  logic [15:0] rdata;
  logic irq;
  logic sampleTick;
  logic [3:0] cmpOut;
  logic rdSeen = 1'b0;
  logic [15:0] v;
  gtc_note_t note;
  gtc_note_t noteQ[$];
  int badCount = 0;
  int cmpCount = 0;
  int tickCnt = 0;
  logic [7:0] bufOffs [6] = '{OFF_PRESCALE, OFF_RELOAD, OFF_CMP1, OFF_CMP2, OFF_CMP3, OFF_CMP4};
  logic [15:0] caseCtrl [7] = '{16'h0002, 16'h0004, 16'h0000, 16'h0000, 16'h0004, 16'h0002, 16'h0010};
  int caseSrc [7] = '{0, 0, 0, 1, 1, 2, 2};
  logic [15:0] caseExp [7] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0001};

  gtc_core dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
    .rdStb(rdStb), .triggerIn(triggerIn), .followerUpdate(followerUpdate), .rdata(rdata),
    .irq(irq), .sampleTick(sampleTick), .cmpOut(cmpOut));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s exp=%h seen=%h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wdata <= d;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    noteQ.push_back('{what, e, m});
    bus(1'b0, 1'b1, a, ZERO16);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, ZERO16);
  endtask : idle

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // read monitor and tick counter
  always @(posedge clock) rdSeen <= rdStb;
  always @(negedge clock) begin
    if (arst_n && sampleTick) tickCnt++;
    if (rdSeen && noteQ.size() > 0) begin
      note = noteQ.pop_front();
      check(note.what, rdata & note.msk, note.exp & note.msk);
    end
  end

  initial begin
    #(50 * 5000);
    badCount++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = ZERO16;
    wrStb = 1'b0;
    rdStb = 1'b0;
    triggerIn = 1'b0;
    followerUpdate = 1'b0;
    void'($urandom(32'hF0BA3484));
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd("control reset", OFF_CTRL_ONE, CTRL_ONE_RESET, 16'hFFFF);
    rd("unmapped", 8'h30, ZERO16, 16'hFFFF);
    rd("event register", OFF_SW_EVENT, ZERO16, 16'hFFFF);
    foreach (bufOffs[i]) begin
      v = 16'($urandom);
      wr(bufOffs[i], v);
      rd("buffered register", bufOffs[i], v, 16'hFFFF);
    end
    wr(OFF_PRESCALE, ZERO16);
    $display("map test done");
    for (int i = 0; i < 4; i++) begin
      v = (16'($urandom) & 16'hFF9E) | 16'(i << ALIGN_LO);
      wr(OFF_CTRL_ONE, v);
      v = v & CTRL_ONE_MASK;
      if (i != 0) v[DIR_BIT] = 1'b0;
      rd("control", OFF_CTRL_ONE, v, 16'hFFFF);
    end
    $display("control test done");
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CTRL_ONE, 16'(d << DIV_LO));
      idle(8);
      tickCnt = 0;
      idle(8);
      check("tick count", 16'(tickCnt), (d == 1) ? 16'h0004 : (d == 2) ? 16'h0002 : 16'h0008);
    end
    $display("divider test done");
    for (int p = 0; p < 2; p++) begin
      wr(OFF_CTRL_ONE, 16'(p << PRELOAD_BIT));
      wr(OFF_RELOAD, 16'h0003);
      wr(OFF_SW_EVENT, ONE16);
      wr(OFF_FLAGS, ONE16);
      wr(OFF_RELOAD, 16'h00C8);
      wr(OFF_CTRL_ONE, 16'(p << PRELOAD_BIT) | ONE16);
      idle(20);
      wr(OFF_CTRL_ONE, 16'(p << PRELOAD_BIT));
      rd("wrap flag", OFF_FLAGS, 16'(p), ONE16);
    end
    $display("preload test done");
    wr(OFF_CTRL_ONE, ZERO16);
    wr(OFF_RELOAD, 16'h0003);
    for (int k = 0; k < 7; k++) begin
      wr(OFF_FLAGS, FLAG_MASK);
      wr(OFF_CTRL_ONE, caseCtrl[k]);
      if (caseSrc[k] == 0) begin
        wr(OFF_SW_EVENT, ONE16);
      end else if (caseSrc[k] == 1) begin
        followerUpdate <= 1'b1;
        idle(1);
        followerUpdate <= 1'b0;
      end else begin
        wr(OFF_CTRL_ONE, caseCtrl[k] | ONE16);
        idle(20);
        wr(OFF_CTRL_ONE, caseCtrl[k]);
      end
      idle(1);
      rd("update source", OFF_FLAGS, caseExp[k], ONE16);
    end
    $display("update source test done");
    wr(OFF_IRQ_EN, ONE16);
    wr(OFF_SW_EVENT, ONE16);
    idle(3);
    check("irq raised", {15'h0000, irq}, ONE16);
    wr(OFF_IRQ_EN, ZERO16);
    idle(3);
    check("irq masked", {15'h0000, irq}, ZERO16);
    wr(OFF_IRQ_EN, ONE16);
    wr(OFF_FLAGS, ONE16);
    idle(3);
    check("irq cleared", {15'h0000, irq}, ZERO16);
    $display("interrupt test done");
    wr(OFF_CTRL_ONE, 16'h0009);
    idle(20);
    rd("one shot stop", OFF_CTRL_ONE, ZERO16, ONE16);
    wr(OFF_CTRL_ONE, ZERO16);
    wr(OFF_COUNT, 16'h0003);
    idle(5);
    rd("stopped count", OFF_COUNT, 16'h0003, 16'hFFFF);
    wr(OFF_FOLLOWER, {13'h0000, FOLLOW_TRIGGER});
    idle(2);
    triggerIn <= 1'b1;
    idle(3);
    rd("trigger start", OFF_CTRL_ONE, ONE16, ONE16);
    triggerIn <= 1'b0;
    idle(3);
    $display("one shot and trigger test done");
    wr(OFF_CTRL_ONE, ZERO16);
    wr(OFF_RELOAD, 16'h00C8);
    wr(OFF_CMP1, 16'h0100);
    wr(OFF_CMP2, ZERO16);
    wr(OFF_CH_OUT_EN, 16'h0011);
    wr(OFF_SW_EVENT, ONE16);
    wr(OFF_CTRL_ONE, ONE16);
    idle(4);
    check("channel outputs", {12'h000, cmpOut}, 16'h0001);
    $display("channel output test done");
    end_of_test();
  end
endmodule : gtc_core_tb
